// ---- swc_top.sv ----
// sleep entry and wake-up sequencer with axi4-lite control and status
// assumes core strobes are one-cycle pulses synchronous to clk
`timescale 1ns/1ps
module swc_top #(
	parameter int NSRC = 8,
	parameter logic [NSRC-1:0] WAKE_MASK = 8'hFF,
	parameter int WDT_WIDTH = 16,
	parameter logic [WDT_WIDTH-1:0] WDT_LIMIT = 16'hFFFF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// core strobes
	input wire logic sleep_instr,
	input wire logic watchdog_clear_instr,
	input wire logic global_int_enable,
	// interrupt sources
	input wire logic [NSRC-1:0] int_flags,
	input wire logic [NSRC-1:0] int_enables,
	// configuration and pins
	input wire logic wdt_cfg_enable,
	input wire logic master_clear_pin_n,
	// master clear pin driver, never enabled
	output logic master_clear_out,
	output logic master_clear_oe,
	// clock and io control
	output logic osc_enable,
	output logic io_hold,
	output logic core_halt,
	// core sequencing pulses
	output logic prefetch_next,
	output logic exec_post_sleep,
	output logic dummy_cycle,
	output logic vector_branch,
	output logic sleep_nop,
	output logic device_reset,
	// status flags
	output logic power_down_flag,
	output logic timeout_flag
);
	generate
		if (NSRC < 1 || NSRC > 24) begin : g_chk
			$error("interrupt source count out of range");
		end
	endgenerate

	swc_pkg::swc_state_t st_q; // sequencer state
	swc_pkg::swc_state_t st_d; // next state
	logic [10:0] start_q; // start-up timer
	logic pend_q; // enabled wake flag seen last cycle
	logic wake_int_q; // wake-up came from an interrupt
	logic [1:0] cause_q; // last wake cause
	logic pd_q; // power-down flag
	logic to_q; // time-out flag
	logic [31:0] ctrl_q; // control register
	logic osc_q, hold_q, halt_q; // clock and io control
	logic pf_q, post_q, dummy_q, vec_q, nop_q, rst_q; // core pulses
	logic [WDT_WIDTH-1:0] wdt_count; // watchdog count
	logic wdt_timeout; // watchdog time-out pulse

	// wake request from clock-independent enabled sources only
	wire pend = |(int_flags & int_enables & WAKE_MASK); // [R11] [R13]
	wire wdt_en = wdt_cfg_enable | ctrl_q[swc_pkg::CTRL_WDT_EN];
	wire in_run = (st_q == swc_pkg::SWC_RUN);
	wire asleep = (st_q == swc_pkg::SWC_SLEEP);
	// sleep only from the instruction; a flag pending beforehand makes it a nop
	wire sleep_go = in_run && sleep_instr && !pend_q; // [R01] [R18]
	wire sleep_skip = in_run && sleep_instr && pend_q; // [R17]
	wire wake_pin = asleep && !master_clear_pin_n; // [R08]
	wire wake_wdt = asleep && master_clear_pin_n && wdt_en && wdt_timeout; // [R08]
	wire wake_int = asleep && master_clear_pin_n && !wake_wdt && pend; // [R08] [R15]
	wire wake_any = wake_wdt || wake_int;
	wire start_done = (start_q == swc_pkg::START_LAST);
	wire in_start = (st_q == swc_pkg::SWC_START);
	wire run_wdt_rst = in_run && wdt_en && wdt_timeout;
	// watchdog clear: instruction, sleep entry, any wake, held during start-up
	wire wdt_clr = watchdog_clear_instr || sleep_go || wake_any || wake_pin
		|| in_start; // [R02] [R16] [R21]

	swc_watchdog #(
		.WIDTH(WDT_WIDTH),
		.LIMIT(WDT_LIMIT)
	) u_wdt (
		.clk(clk),
		.rst(rst),
		.enable(wdt_en),
		.clear(wdt_clr),
		.count(wdt_count),
		.timeout(wdt_timeout)
	);

	// next state of the sequencer
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			swc_pkg::SWC_RUN: begin
				if (sleep_go) begin
					st_d = swc_pkg::SWC_SLEEP;
				end
			end
			swc_pkg::SWC_SLEEP: begin
				if (wake_pin) begin
					st_d = swc_pkg::SWC_RUN; // [R09]
				end else if (wake_any && ctrl_q[swc_pkg::CTRL_XTAL]) begin
					st_d = swc_pkg::SWC_START; // [R21]
				end else if (wake_any) begin
					st_d = swc_pkg::SWC_POST;
				end
			end
			swc_pkg::SWC_START: begin
				if (start_done) begin
					st_d = swc_pkg::SWC_POST;
				end
			end
			swc_pkg::SWC_POST: begin
				// vector only for an interrupt wake with global enable
				if (wake_int_q && global_int_enable) begin
					st_d = swc_pkg::SWC_DUMMY1; // [R14]
				end else begin
					st_d = swc_pkg::SWC_RUN; // [R09] [R14]
				end
			end
			swc_pkg::SWC_DUMMY1: begin
				st_d = swc_pkg::SWC_DUMMY2; // [R22]
			end
			swc_pkg::SWC_DUMMY2: begin
				st_d = swc_pkg::SWC_VECTOR; // [R22]
			end
			swc_pkg::SWC_VECTOR: begin
				st_d = swc_pkg::SWC_RUN;
			end
			default: begin
				st_d = swc_pkg::SWC_RUN;
			end
		endcase
	end

	// state, start-up timer and wake bookkeeping
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= swc_pkg::SWC_RUN;
			start_q <= '0;
			pend_q <= 1'b0;
			wake_int_q <= 1'b0;
			cause_q <= swc_pkg::CAUSE_NONE;
		end else begin
			st_q <= st_d;
			start_q <= in_start ? start_q + 11'h001 : 11'h000;
			pend_q <= pend;
			if (wake_any) begin
				wake_int_q <= wake_int;
			end
			if (wake_pin) begin
				cause_q <= swc_pkg::CAUSE_PIN;
			end else if (wake_wdt) begin
				cause_q <= swc_pkg::CAUSE_WDT;
			end else if (wake_int) begin
				cause_q <= swc_pkg::CAUSE_INT;
			end
		end
	end

	// power-down and time-out flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pd_q <= swc_pkg::RST_PD;
			to_q <= swc_pkg::RST_TO;
		end else if (sleep_go) begin
			pd_q <= 1'b0; // [R03] [R18]
			to_q <= 1'b1; // [R03] [R18]
		end else if (wake_wdt || run_wdt_rst) begin
			to_q <= 1'b0; // [R10]
		end else if (watchdog_clear_instr) begin
			pd_q <= 1'b1;
			to_q <= 1'b1;
		end
	end

	// oscillator, io hold and core pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_q <= 1'b1;
			hold_q <= 1'b0;
			halt_q <= 1'b0;
			pf_q <= 1'b0;
			post_q <= 1'b0;
			dummy_q <= 1'b0;
			vec_q <= 1'b0;
			nop_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			osc_q <= (st_d != swc_pkg::SWC_SLEEP); // [R04]
			hold_q <= (st_d == swc_pkg::SWC_SLEEP) || (st_d == swc_pkg::SWC_START); // [R05]
			halt_q <= (st_d == swc_pkg::SWC_SLEEP) || (st_d == swc_pkg::SWC_START);
			pf_q <= sleep_go; // [R12]
			post_q <= (st_d == swc_pkg::SWC_POST); // [R14]
			dummy_q <= (st_d == swc_pkg::SWC_DUMMY1) || (st_d == swc_pkg::SWC_DUMMY2); // [R22]
			vec_q <= (st_d == swc_pkg::SWC_VECTOR); // [R14]
			nop_q <= sleep_skip; // [R17]
			rst_q <= wake_pin || run_wdt_rst || (in_run && !master_clear_pin_n); // [R09]
		end
	end

	assign osc_enable = osc_q;
	assign io_hold = hold_q;
	assign core_halt = halt_q;
	assign prefetch_next = pf_q;
	assign exec_post_sleep = post_q;
	assign dummy_cycle = dummy_q;
	assign vector_branch = vec_q;
	assign sleep_nop = nop_q;
	assign device_reset = rst_q;
	assign power_down_flag = pd_q;
	assign timeout_flag = to_q;

	// master clear driver stays released, also on watchdog reset
	logic mc_out_q, mc_oe_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mc_out_q <= 1'b0;
			mc_oe_q <= 1'b0;
		end else begin
			mc_out_q <= 1'b0;
			mc_oe_q <= 1'b0; // [R07]
		end
	end
	assign master_clear_out = mc_out_q;
	assign master_clear_oe = mc_oe_q;

	// ---- axi4-lite slave ----
	logic awr_q, wr_q, aw_got_q, w_got_q, bv_q, arr_q, rv_q;
	logic [3:0] awa_q; // latched write offset
	logic [31:0] wd_q; // latched write data
	logic [3:0] ws_q; // latched strobes
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// register decode, used for reads and writes
	function automatic logic hit(input logic [31:0] a);
		hit = (a[31:4] == 28'h0000000) && (a[1:0] == 2'h0);
	endfunction
	wire do_write = aw_got_q && w_got_q && !bv_q;
	wire wr_hit = (awa_q[1:0] == 2'h0) && awa_q[3:2] <= 2'h3;
	wire [31:0] status_w = {27'h0, st_q, to_q, pd_q};
	wire [31:0] wdt_w = 32'(wdt_count);
	wire [31:0] cause_w = {30'h0, cause_q};
	wire [3:0] ara = s_axi_araddr[3:0];
	wire [31:0] rd_mux = (ara == swc_pkg::OFF_CTRL) ? ctrl_q :
		(ara == swc_pkg::OFF_STATUS) ? status_w :
		(ara == swc_pkg::OFF_WDT) ? wdt_w : cause_w;

	// write channels, taken in either order
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awr_q <= 1'b0;
			wr_q <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			bv_q <= 1'b0;
			bresp_q <= swc_pkg::RESP_OKAY;
			awa_q <= '0;
			wd_q <= '0;
			ws_q <= '0;
			ctrl_q <= swc_pkg::RST_CTRL;
		end else begin
			awr_q <= !aw_got_q && !bv_q && !(awr_q && s_axi_awvalid) && !do_write;
			wr_q <= !w_got_q && !bv_q && !(wr_q && s_axi_wvalid) && !do_write;
			if (awr_q && s_axi_awvalid) begin
				aw_got_q <= 1'b1;
				awa_q <= hit(s_axi_awaddr) ? s_axi_awaddr[3:0] : 4'h1;
			end
			if (wr_q && s_axi_wvalid) begin
				w_got_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				bv_q <= 1'b1;
				bresp_q <= wr_hit ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
				if (awa_q == swc_pkg::OFF_CTRL && ws_q[0]) begin
					ctrl_q <= {30'h0, wd_q[swc_pkg::CTRL_XTAL], wd_q[swc_pkg::CTRL_WDT_EN]};
				end
			end else if (bv_q && s_axi_bready) begin
				bv_q <= 1'b0;
			end
		end
	end

	// read channel, one outstanding
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arr_q <= 1'b0;
			rv_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= swc_pkg::RESP_OKAY;
		end else if (arr_q && s_axi_arvalid) begin
			arr_q <= 1'b0;
			rv_q <= 1'b1;
			rdata_q <= hit(s_axi_araddr) ? rd_mux : 32'h0000_0000;
			rresp_q <= hit(s_axi_araddr) ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
		end else if (rv_q && s_axi_rready) begin
			rv_q <= 1'b0;
			arr_q <= 1'b1;
		end else if (!rv_q) begin
			arr_q <= 1'b1;
		end
	end

	assign s_axi_awready = awr_q;
	assign s_axi_wready = wr_q;
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arr_q;
	assign s_axi_rvalid = rv_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ---- checks ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_post_vec;
		exec_post_sleep && wake_int_q && global_int_enable;
	endsequence
	sequence s_two_dummy_vec;
		dummy_cycle ##1 dummy_cycle ##1 vector_branch;
	endsequence

	AST_SLEEP_ONLY_INSTR: assert property ($rose(core_halt) |-> $past(sleep_instr)) // [R01]
		else $error("sleep entered without instruction");
	AST_SLEEP_CLR_WDT: assert property (sleep_go |=> wdt_count == '0) // [R02]
		else $error("watchdog not cleared on sleep");
	AST_SLEEP_FLAGS: assert property (sleep_go |=> !power_down_flag && timeout_flag) // [R03]
		else $error("flags wrong after sleep entry");
	AST_OSC_OFF: assert property (sleep_go |=> !osc_enable && io_hold) // [R04]
		else $error("oscillator or hold wrong in sleep");
	AST_IO_HELD: assert property (asleep |-> io_hold) // [R05]
		else $error("io not held during sleep");
	AST_PIN_FREE: assert property (!master_clear_oe) // [R07]
		else $error("master clear pin driven");
	AST_PIN_RESET: assert property (wake_pin |=> device_reset && !core_halt) // [R09]
		else $error("master clear wake without reset");
	AST_WDT_WAKE_TO: assert property (wake_wdt |=> !timeout_flag && !device_reset) // [R10]
		else $error("time-out flag kept on watchdog wake");
	AST_NOP_KEEPS: assert property (sleep_skip |=> $stable(power_down_flag)
		&& $stable(timeout_flag) && sleep_nop && !core_halt) // [R17]
		else $error("nop sleep altered state");
	AST_PREFETCH: assert property (sleep_go |=> prefetch_next) // [R12]
		else $error("no prefetch on sleep");
	AST_VECTOR_SEQ: assert property (s_post_vec |=> s_two_dummy_vec) // [R22]
		else $error("vector sequence wrong");
	AST_INT_WAKE: assert property (asleep && master_clear_pin_n && pend |=> !asleep) // [R15]
		else $error("pending interrupt did not wake");
endmodule

// ---- swc_pkg.sv ----
// constants, register map and state codes of the sleep and wake-up controller
// assumes one system clock at 200 MHz standing in for the core oscillator
//
// Operation
// R01: sleep entered only by sleep instruction
// R02: sleep clears watchdog, watchdog keeps counting
// R03: sleep clears power-down, sets time-out flag
// R04: oscillator driver off during sleep
// R05: io pins hold their pre-sleep drive
// R06: master clear pin held high while asleep
// R07: watchdog reset never drives master clear
// R08: wake on master clear, watchdog, interrupt
// R09: master clear resets; others resume program
// R10: watchdog wake clears time-out flag
// R11: only clock-independent sources may wake
// R12: next instruction prefetched during sleep instruction
// R13: wake needs individual enable, ignores global
// R14: run prefetched instruction, then vector if enabled
// R15: pending enabled flag wakes right after sleep
// R16: every wake-up clears the watchdog
// R17: interrupt before sleep: sleep is a nop
// R18: interrupt during sleep: full entry, then wake
// R19: software reads power-down flag after sleep
// R20: software clears watchdog before sleep itself
// R21: crystal clock: watchdog cleared until start-up ends
// R22: two dummy cycles before vector instruction
package swc_pkg;
	// register byte offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_WDT = 4'h8;
	localparam logic [3:0] OFF_CAUSE = 4'hC;
	// control field positions
	localparam int CTRL_WDT_EN = 0;
	localparam int CTRL_XTAL = 1;
	// status field positions
	localparam int ST_PD = 0;
	localparam int ST_TO = 1;
	localparam int ST_STATE_LO = 2;
	// wake cause codes
	localparam logic [1:0] CAUSE_NONE = 2'h0;
	localparam logic [1:0] CAUSE_PIN = 2'h1;
	localparam logic [1:0] CAUSE_WDT = 2'h2;
	localparam logic [1:0] CAUSE_INT = 2'h3;
	// reset values
	localparam logic RST_PD = 1'b1;
	localparam logic RST_TO = 1'b1;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing: oscillator start-up in oscillator periods, one per clk
	localparam int CLK_MHZ = 200;
	localparam int START_PERIODS = 1024;
	localparam int START_CYCLES = START_PERIODS;
	localparam logic [10:0] START_LAST = 11'(START_CYCLES - 1);
	// sequencer states
	typedef enum logic [2:0] {
		SWC_RUN = 3'h0,
		SWC_SLEEP = 3'h1,
		SWC_START = 3'h2,
		SWC_POST = 3'h3,
		SWC_DUMMY1 = 3'h4,
		SWC_DUMMY2 = 3'h5,
		SWC_VECTOR = 3'h6
	} swc_state_t;
endpackage

// ---- swc_watchdog.sv ----
// watchdog counter with synchronous clear and a one-cycle time-out pulse
// assumes clear and enable come from the sequencer on the same clock
`timescale 1ns/1ps
module swc_watchdog #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] LIMIT = 16'hFFFF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic enable,
	input wire logic clear,
	// state
	output logic [WIDTH-1:0] count,
	output logic timeout
);
	generate
		if (WIDTH < 2) begin : g_chk
			$error("watchdog width too small");
		end
	endgenerate

	logic [WIDTH-1:0] count_q; // running count
	logic timeout_q; // pulse at terminal count

	assign count = count_q;
	assign timeout = timeout_q;

	// count while enabled, wrap at limit with a pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= '0;
			timeout_q <= 1'b0;
		end else if (clear || !enable) begin
			count_q <= '0;
			timeout_q <= 1'b0;
		end else if (count_q == LIMIT) begin
			count_q <= '0;
			timeout_q <= 1'b1;
		end else begin
			count_q <= count_q + 1'b1;
			timeout_q <= 1'b0;
		end
	end
endmodule

// ---- swc_core_model.sv ----
// core side model: issues instruction strobes, counts sequencing pulses
// assumes bench requests are one-cycle pulses on clk, controller pulses are flop outputs
`timescale 1ns/1ps
module swc_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// program flow requests from the bench
	input wire logic req_sleep,
	input wire logic req_clr,
	// instruction strobes to the controller
	output logic sleep_instr,
	output logic watchdog_clear_instr,
	// sequencing pulses from the controller
	input wire logic prefetch_next,
	input wire logic exec_post_sleep,
	input wire logic dummy_cycle,
	input wire logic vector_branch,
	input wire logic sleep_nop,
	input wire logic device_reset,
	// event counts seen by the core
	output logic [7:0] n_pre,
	output logic [7:0] n_post,
	output logic [7:0] n_dum,
	output logic [7:0] n_vec,
	output logic [7:0] n_nop,
	output logic [7:0] n_rst
);
	// strobes follow requests by one cycle; counters tally each pulse cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sleep_instr <= 1'b0;
			watchdog_clear_instr <= 1'b0;
			{n_pre, n_post, n_dum, n_vec, n_nop, n_rst} <= 48'h0;
		end else begin
			sleep_instr <= req_sleep;
			watchdog_clear_instr <= req_clr;
			n_pre <= n_pre + 8'(prefetch_next);
			n_post <= n_post + 8'(exec_post_sleep);
			n_dum <= n_dum + 8'(dummy_cycle);
			n_vec <= n_vec + 8'(vector_branch);
			n_nop <= n_nop + 8'(sleep_nop);
			n_rst <= n_rst + 8'(device_reset);
		end
	end
endmodule

// ---- sleep_wakeup_control_bench.sv ----
// self-checking bench for the sleep and wake-up controller
// assumes axi4-lite register map of the package and a shortened watchdog limit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module sleep_wakeup_control_bench;
	logic clk, rst; // clock and reset
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata; // axi payloads
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic sleep_instr, watchdog_clear_instr, global_int_enable; // core side
	logic [7:0] int_flags, int_enables; // wake sources
	logic wdt_cfg_enable, master_clear_pin_n, master_clear_out, master_clear_oe;
	logic osc_enable, io_hold, core_halt, prefetch_next, exec_post_sleep, dummy_cycle;
	logic vector_branch, sleep_nop, device_reset, power_down_flag, timeout_flag;
	logic req_sleep, req_clr; // program flow requests
	logic [7:0] n_pre, n_post, n_dum, n_vec, n_nop, n_rst; // core event counts
	int errors = 0, n_tests = 0, cyc = 0;
	swc_top #(.NSRC(8), .WAKE_MASK(8'hFF), .WDT_WIDTH(16), .WDT_LIMIT(16'h0020)) u_dut (
		.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sleep_instr, .watchdog_clear_instr,
		.global_int_enable, .int_flags, .int_enables, .wdt_cfg_enable, .master_clear_pin_n,
		.master_clear_out, .master_clear_oe, .osc_enable, .io_hold, .core_halt,
		.prefetch_next, .exec_post_sleep, .dummy_cycle, .vector_branch, .sleep_nop,
		.device_reset, .power_down_flag, .timeout_flag);
	swc_core_model u_core (.clk, .rst, .req_sleep, .req_clr, .sleep_instr,
		.watchdog_clear_instr, .prefetch_next, .exec_post_sleep, .dummy_cycle,
		.vector_branch, .sleep_nop, .device_reset, .n_pre, .n_post, .n_dum, .n_vec,
		.n_nop, .n_rst);
	// free-running 200 mhz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// verdict and end of run
	task automatic conclude();
		if (errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			conclude();
		end
	end
	// expected status word from flags and state code
	function automatic logic [31:0] st(int pd, int to, swc_pkg::swc_state_t s);
		return {27'h0, s, to[0], pd[0]};
	endfunction
	// axi4-lite write, both channels offered together
	task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && s_axi_awready === 1'b1) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
			if (w && s_axi_wready === 1'b1) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
		end
		s_axi_bready <= 1'b1;
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, s_axi_bresp)
	endtask
	// axi4-lite read with data and response compare
	task automatic axr(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK("rdata", ed, s_axi_rdata)
		`CHK("rresp", er, s_axi_rresp)
	endtask
	// one-cycle program request, then let the controller settle
	task automatic pulse(input logic slp);
		@(posedge clk);
		if (slp) req_sleep <= 1'b1; else req_clr <= 1'b1;
		@(posedge clk);
		req_sleep <= 1'b0;
		req_clr <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// bounded wait for the core to be released
	task automatic wait_run();
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			if (core_halt === 1'b0) break;
		end
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{global_int_enable, wdt_cfg_enable, req_sleep, req_clr} = 4'h0;
		int_flags = 8'h00;
		int_enables = 8'h01;
		master_clear_pin_n = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		axr(swc_pkg::OFF_STATUS, st(1, 1, swc_pkg::SWC_RUN), swc_pkg::RESP_OKAY);
		axr(swc_pkg::OFF_CTRL, swc_pkg::RST_CTRL, swc_pkg::RESP_OKAY);
		`CHK("osc", 1'b1, osc_enable)
		// access kinds: read-only ignored, unmapped refused
		axw(swc_pkg::OFF_STATUS, 32'h0000_0000, swc_pkg::RESP_OKAY);
		axw(32'h0000_0040, 32'h0000_0001, swc_pkg::RESP_SLVERR);
		axr(32'h0000_0040, 32'h0000_0000, swc_pkg::RESP_SLVERR);
		axr(swc_pkg::OFF_STATUS, st(1, 1, swc_pkg::SWC_RUN), swc_pkg::RESP_OKAY);
		// interrupt wake with global enable: post instruction, dummies, vector
		global_int_enable <= 1'b1;
		pulse(1'b1);
		`CHK("osc", 1'b0, osc_enable)
		`CHK("hold", 1'b1, io_hold)
		axr(swc_pkg::OFF_STATUS, st(0, 1, swc_pkg::SWC_SLEEP), swc_pkg::RESP_OKAY);
		int_flags <= 8'h01;
		wait_run();
		repeat (5) @(posedge clk);
		`CHK("pre", 8'h01, n_pre)
		`CHK("post", 8'h01, n_post)
		`CHK("dum", 8'h02, n_dum)
		`CHK("vec", 8'h01, n_vec)
		axr(swc_pkg::OFF_CAUSE, 32'(swc_pkg::CAUSE_INT), swc_pkg::RESP_OKAY);
		// enabled flag pending before sleep: taken as nop, flags untouched
		global_int_enable <= 1'b0;
		pulse(1'b0);
		pulse(1'b1);
		`CHK("nop", 8'h01, n_nop)
		`CHK("osc", 1'b1, osc_enable)
		axr(swc_pkg::OFF_STATUS, st(1, 1, swc_pkg::SWC_RUN), swc_pkg::RESP_OKAY);
		// flag without its enable keeps sleeping; master clear then resets
		int_flags <= 8'h02;
		axw(swc_pkg::OFF_CTRL, 32'h0000_0002, swc_pkg::RESP_OKAY);
		axr(swc_pkg::OFF_CTRL, 32'h0000_0002, swc_pkg::RESP_OKAY);
		pulse(1'b1);
		repeat (20) @(posedge clk);
		axr(swc_pkg::OFF_STATUS, st(0, 1, swc_pkg::SWC_SLEEP), swc_pkg::RESP_OKAY);
		master_clear_pin_n <= 1'b0;
		@(posedge clk);
		master_clear_pin_n <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("rst", 8'h01, n_rst)
		`CHK("halt", 1'b0, core_halt)
		axr(swc_pkg::OFF_CAUSE, 32'(swc_pkg::CAUSE_PIN), swc_pkg::RESP_OKAY);
		// crystal mode: start-up wait before resuming in line, no vector
		int_flags <= 8'h00;
		pulse(1'b1);
		int_flags <= 8'h01;
		repeat (500) @(posedge clk);
		`CHK("halt", 1'b1, core_halt)
		wait_run();
		repeat (4) @(posedge clk);
		`CHK("post", 8'h02, n_post)
		`CHK("dum", 8'h02, n_dum)
		`CHK("vec", 8'h01, n_vec)
		int_flags <= 8'h00;
		axw(swc_pkg::OFF_CTRL, 32'h0000_0000, swc_pkg::RESP_OKAY);
		// watchdog wake resumes and clears time-out
		wdt_cfg_enable <= 1'b1;
		pulse(1'b1);
		wait_run();
		wdt_cfg_enable <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("post", 8'h03, n_post)
		`CHK("rst", 8'h01, n_rst)
		axr(swc_pkg::OFF_STATUS, st(0, 0, swc_pkg::SWC_RUN), swc_pkg::RESP_OKAY);
		`CHK("to", 1'b0, timeout_flag)
		`CHK("pd", 1'b0, power_down_flag)
		axr(swc_pkg::OFF_CAUSE, 32'(swc_pkg::CAUSE_WDT), swc_pkg::RESP_OKAY);
		// watchdog time-out while running resets without driving the pin
		wdt_cfg_enable <= 1'b1;
		repeat (80) @(posedge clk);
		wdt_cfg_enable <= 1'b0;
		`CHK("rst", 1'b1, n_rst > 8'h01)
		`CHK("pin_oe", 1'b0, master_clear_oe)
		`CHK("pin_out", 1'b0, master_clear_out)
		conclude();
	end
endmodule
